// [rtl/msg_sel_pkg.sv]
// Operation
// RULE1: Active inputs select messages; lowest message number always wins.
// RULE2: Shown message holds until a higher one appears or it drops.
// RULE3: Inputs whose message is not programmed are ignored.
// RULE4: With no active input show idle message 17, or 21 in twenty-input mode.
// RULE5: Idle message unprogrammed: show fixed idle-not-programmed error instead.
// RULE6: Input lines are examined in ascending order over 8 or 16 lines.
// RULE7: Display only after strobe held for one scan plus debounce time.
// RULE8: Port watched continuously; higher input replaces message while strobe active.
// RULE9: No variable data; data-select lines choose an alternate message bank.
// RULE10: Bank gives up to seven alternates per input, base plus hundreds.
// RULE11: Three bank lines form bank 0..7; add bank times 100.
// RULE12: Twenty/twelve-input mode uses control terminals as extra discrete inputs.
// RULE13: Twenty-input mode: strobe is a plain input, not a gate.
// RULE14: Display-mode entry shows self-test for at least 3 s, then clears.
// RULE15: After entry, show message when strobe enabled and message line set.
// RULE16: Unprogrammed message memory: show memory-inoperative message, no operation.
// RULE17: Operation is a repeating scan of 1 to 75 ms.
// RULE18: Accept new value only after equal reads for two scans plus debounce.
// RULE19: Any differing read restarts acceptance with the new candidate.
// RULE20: Controller holds lines one scan plus debounce or another scan.
// RULE21: Saver enabled: blank after port inactive for the saver time.
// RULE22: Blank persists until valid input, which restarts the saver timer.
// RULE23: Eight-line port value limited to 99 BCD or 255 binary.
package msg_sel_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int SELFTEST_MS = 3000;
    localparam int SELFTEST_CYC = CLK_HZ / 1000 * SELFTEST_MS;
    localparam int SCAN_MS = 1;
    localparam int SCAN_CYC = CLK_HZ / 1000 * SCAN_MS;
    localparam int PORT_W = 20;
    localparam int MSG_W = 10;
    localparam logic [MSG_W-1:0] IDLE_MSG = 10'h011;
    localparam logic [MSG_W-1:0] IDLE_MSG_20 = 10'h015;
    localparam logic [MSG_W-1:0] BANK_STEP = 10'h064;
    // Register word indices
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_DEBOUNCE = 3'h1;
    localparam logic [2:0] REG_SAVER = 3'h2;
    localparam logic [2:0] REG_PROG = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;
    localparam logic [2:0] REG_MSG = 3'h5;
    localparam logic [2:0] REG_PORTVAL = 3'h6;
    // CTRL fields
    localparam int CTRL_ENTER = 0;
    localparam int CTRL_WIDE = 1;
    localparam int CTRL_TWENTY = 2;
    localparam int CTRL_BINARY = 3;
    localparam int CTRL_SAVER = 4;
    localparam int CTRL_MEMOK = 5;
    localparam logic [5:0] CTRL_RST = 6'h02;
    localparam logic [7:0] DEBOUNCE_RST = 8'h02;
    localparam logic [15:0] SAVER_RST = 16'hffff;
    localparam logic [21:0] PROG_RST = 22'h00_0000;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_INOP,
        ST_SELFTEST,
        ST_RUN
    } state_t;
endpackage

// [rtl/priority_message_selector.sv]
// Chosen here: the Avalon-MM slave port and the register addresses.
module priority_message_selector
    import msg_sel_pkg::*;
#(
    parameter int SCAN_CYCLES = msg_sel_pkg::SCAN_CYC,
    parameter int SELFTEST_CYCLES = msg_sel_pkg::SELFTEST_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [2:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [15:0] discrete_i,
    input wire logic [2:0] bank_sel_i,
    input wire logic strobe_i,
    output logic [msg_sel_pkg::MSG_W-1:0] msg_num_o,
    output logic msg_valid_o,
    output logic show_selftest_o,
    output logic show_inop_o,
    output logic show_idle_err_o,
    output logic blank_o,
    output logic scan_tick_o
);
    import msg_sel_pkg::*;

    logic [5:0] ctrl_r;
    logic [7:0] debounce_r;
    logic [15:0] saver_r;
    logic [21:0] prog_r;
    logic ack_r;
    logic [31:0] rdata_r;
    state_t state_r;
    logic [31:0] st_cnt_r;
    logic [31:0] scan_cnt_r;
    logic scan_tick;
    logic [PORT_W-1:0] sync1_r;
    logic [PORT_W-1:0] sync2_r;
    logic [PORT_W-1:0] sync3_r;
    logic [PORT_W-1:0] stable_r;
    logic [PORT_W-1:0] cand_r;
    logic [PORT_W-1:0] acc_r;
    logic [8:0] match_r;
    logic new_acc;
    logic [15:0] idle_scans_r;
    logic [MSG_W-1:0] msg_r;
    logic [MSG_W-1:0] msg_nxt;
    logic valid_r;
    logic valid_nxt;
    logic idle_err_r;
    logic idle_err_nxt;
    logic blank_r;
    logic upd_r;
    logic [15:0] portval_r;
    logic [PORT_W-1:0] eff_port;
    logic [2:0] eff_bank;
    logic [4:0] pick;
    logic gate_ok;
    logic [MSG_W-1:0] idle_num;

    // Bus access: one wait cycle, then answer
    wire access = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = access & ~ack_r;
    assign avs_readdata_o = rdata_r;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Programmed check uses the base number only, bank lines do not matter
    function automatic logic is_prog(input logic [21:0] map, input logic [4:0] n);
        return map[n];
    endfunction

    function automatic logic [MSG_W-1:0] bank_msg(input logic [4:0] base,
                                                   input logic [2:0] bank);
        return MSG_W'(base) + MSG_W'(bank) * BANK_STEP;
    endfunction

    // Eight-line units see only the low byte
    function automatic logic [15:0] fitted(input logic wide, input logic [15:0] v);
        return wide ? v : {8'h00, v[7:0]};
    endfunction

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access & ~ack_r;
        end
    end

    wire wr_take = avs_write_i & ack_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_r <= CTRL_RST;
            debounce_r <= DEBOUNCE_RST;
            saver_r <= SAVER_RST;
            prog_r <= PROG_RST;
        end else if (wr_take) begin
            case (avs_address_i)
                REG_CTRL: ctrl_r <= 6'(merge({26'h0, ctrl_r}, avs_writedata_i,
                                             avs_byteenable_i));
                REG_DEBOUNCE: debounce_r <= 8'(merge({24'h0, debounce_r}, avs_writedata_i,
                                                     avs_byteenable_i));
                REG_SAVER: saver_r <= 16'(merge({16'h0, saver_r}, avs_writedata_i,
                                                avs_byteenable_i));
                REG_PROG: prog_r <= 22'(merge({10'h0, prog_r}, avs_writedata_i,
                                              avs_byteenable_i));
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read_i & ~ack_r) begin
            case (avs_address_i)
                REG_CTRL: rdata_r <= {26'h0, ctrl_r};
                REG_DEBOUNCE: rdata_r <= {24'h0, debounce_r};
                REG_SAVER: rdata_r <= {16'h0, saver_r};
                REG_PROG: rdata_r <= {10'h0, prog_r};
                REG_STATUS: rdata_r <= {26'h0, blank_r, idle_err_r, valid_r,
                                        scan_tick, state_r};
                REG_MSG: rdata_r <= {22'h0, msg_r};
                REG_PORTVAL: rdata_r <= {16'h0, portval_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Mode state: entry runs self-test, bad memory parks in inoperative
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r <= ST_OFF;
            st_cnt_r <= 32'h0000_0000;
        end else begin
            case (state_r)
                ST_OFF: begin
                    st_cnt_r <= 32'h0000_0000;
                    if (ctrl_r[CTRL_ENTER]) begin
                        state_r <= ctrl_r[CTRL_MEMOK] ? ST_SELFTEST : ST_INOP; // see RULE16
                    end
                end
                ST_INOP: begin
                    if (!ctrl_r[CTRL_ENTER]) begin
                        state_r <= ST_OFF;
                    end
                end
                ST_SELFTEST: begin
                    st_cnt_r <= st_cnt_r + 32'h0000_0001;
                    if (!ctrl_r[CTRL_ENTER]) begin
                        state_r <= ST_OFF;
                    end else if (st_cnt_r >= 32'(SELFTEST_CYCLES - 1)) begin
                        state_r <= ST_RUN; // see RULE14
                    end
                end
                ST_RUN: begin
                    if (!ctrl_r[CTRL_ENTER]) begin
                        state_r <= ST_OFF;
                    end
                end
                default: state_r <= ST_OFF;
            endcase
        end
    end

    // Fixed-period scan; the real loop varies, the fastest case sets the period
    always_ff @(posedge clk_i) begin
        if (srst_i || state_r != ST_RUN) begin
            scan_cnt_r <= 32'h0000_0000;
        end else if (scan_tick) begin
            scan_cnt_r <= 32'h0000_0000;
        end else begin
            scan_cnt_r <= scan_cnt_r + 32'h0000_0001; // see RULE17
        end
    end
    assign scan_tick = (state_r == ST_RUN) && (scan_cnt_r >= 32'(SCAN_CYCLES - 1));
    assign scan_tick_o = scan_tick;

    // Pin sampling: a bit changes only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            stable_r <= '0;
        end else begin
            sync1_r <= {strobe_i, bank_sel_i, discrete_i};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            stable_r <= (sync2_r & ~(sync2_r ^ sync3_r)) | (stable_r & (sync2_r ^ sync3_r));
        end
    end

    // Scan debounce; a value must repeat on 1 + debounce scans
    wire [8:0] need = {1'b0, debounce_r} + 9'h001;
    always_ff @(posedge clk_i) begin
        if (srst_i || state_r != ST_RUN) begin
            cand_r <= '0;
            acc_r <= '0;
            match_r <= 9'h000;
        end else if (scan_tick) begin
            if (stable_r != cand_r) begin
                cand_r <= stable_r; // see RULE19
                match_r <= 9'h000;
            end else if (match_r < need) begin
                match_r <= match_r + 9'h001;
                if (match_r + 9'h001 == need) begin
                    acc_r <= cand_r; // see RULE18
                end
            end
        end
    end
    assign new_acc = scan_tick && (stable_r == cand_r) && (match_r + 9'h001 == need)
                     && (cand_r != acc_r);

    // Which lines count as inputs depends on width and twenty-input mode
    always_comb begin
        eff_port = '0;
        eff_bank = 3'h0;
        case ({ctrl_r[CTRL_WIDE], ctrl_r[CTRL_TWENTY]})
            2'b11: eff_port = acc_r; // see RULE12
            2'b10: begin
                eff_port[15:0] = acc_r[15:0];
                eff_bank = acc_r[18:16]; // see RULE9
            end
            2'b01: eff_port[11:0] = {acc_r[19:16], acc_r[7:0]};
            default: begin
                eff_port[7:0] = acc_r[7:0];
                eff_bank = acc_r[18:16];
            end
        endcase
    end

    // Lowest programmed active input; zero means none
    always_comb begin
        pick = 5'h00;
        for (int i = PORT_W; i >= 1; i--) begin
            if (eff_port[i-1] && is_prog(prog_r, 5'(i))) begin // see RULE3
                pick = 5'(i); // see RULE1 see RULE6
            end
        end
    end

    assign idle_num = ctrl_r[CTRL_TWENTY] ? IDLE_MSG_20 : IDLE_MSG;
    // Strobe gates selection unless it is itself a discrete input
    assign gate_ok = ctrl_r[CTRL_TWENTY] | acc_r[19]; // see RULE7 see RULE13 see RULE15

    // Selection result, applied once per scan
    always_comb begin
        msg_nxt = idle_num;
        valid_nxt = 1'b0;
        idle_err_nxt = 1'b1; // see RULE5
        if (pick != 5'h00) begin
            msg_nxt = bank_msg(pick, eff_bank); // see RULE10 see RULE11
            valid_nxt = 1'b1;
            idle_err_nxt = 1'b0;
        end else if (is_prog(prog_r, idle_num[4:0])) begin
            valid_nxt = 1'b1; // see RULE4
            idle_err_nxt = 1'b0;
        end
    end

    // Display refresh follows the scan; register writes show at the next scan
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            upd_r <= 1'b0;
        end else begin
            upd_r <= scan_tick;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || state_r != ST_RUN) begin
            msg_r <= '0;
            valid_r <= 1'b0;
            idle_err_r <= 1'b0;
        end else if (upd_r && gate_ok) begin // see RULE8 see RULE2
            msg_r <= msg_nxt;
            valid_r <= valid_nxt;
            idle_err_r <= idle_err_nxt;
        end
    end

    // Saver counts scans without a newly accepted port value
    always_ff @(posedge clk_i) begin
        if (srst_i || state_r != ST_RUN) begin
            idle_scans_r <= 16'h0000;
            blank_r <= 1'b0;
        end else if (new_acc) begin
            idle_scans_r <= 16'h0000; // see RULE22
            blank_r <= 1'b0;
        end else if (scan_tick && ctrl_r[CTRL_SAVER]) begin
            if (idle_scans_r >= saver_r) begin
                blank_r <= 1'b1; // see RULE21
            end else begin
                idle_scans_r <= idle_scans_r + 16'h0001;
            end
        end else if (!ctrl_r[CTRL_SAVER]) begin
            idle_scans_r <= 16'h0000;
            blank_r <= 1'b0;
        end
    end

    // Port value as a number, clamped to the fitted width
    function automatic logic [15:0] bcd4(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int d = 3; d >= 0; d--) begin
            r = r * 16'h000a + ((v[d*4 +: 4] > 4'h9) ? 16'h0009 : {12'h0, v[d*4 +: 4]});
        end
        return r;
    endfunction

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            portval_r <= 16'h0000;
        end else if (ctrl_r[CTRL_BINARY]) begin
            portval_r <= fitted(ctrl_r[CTRL_WIDE], acc_r[15:0]); // see RULE23
        end else begin
            portval_r <= bcd4(fitted(ctrl_r[CTRL_WIDE], acc_r[15:0]));
        end
    end

    assign msg_num_o = msg_r;
    assign msg_valid_o = valid_r & ~blank_r;
    assign show_idle_err_o = idle_err_r & ~blank_r;
    assign blank_o = blank_r;
    assign show_selftest_o = (state_r == ST_SELFTEST);
    assign show_inop_o = (state_r == ST_INOP);
endmodule

// [verif/priority_message_selector_checker.sv]
module priority_message_selector_checker
    import msg_sel_pkg::*;
#(
    parameter int SCAN_CYCLES = 8
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic [msg_sel_pkg::MSG_W-1:0] msg_num_o,
    input wire logic msg_valid_o,
    input wire logic show_selftest_o,
    input wire logic show_inop_o,
    input wire logic show_idle_err_o,
    input wire logic blank_o,
    input wire logic scan_tick_o
);
    import msg_sel_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic [15:0] gap_r;
    logic seen_r;
    // Saturating gap since last tick; seen_r skips the first tick after reset
    always_ff @(posedge clk_i) begin
        if (srst_i || scan_tick_o) begin
            gap_r <= 16'h0001;
        end else if (gap_r != 16'hffff) begin
            gap_r <= gap_r + 16'h0001;
        end
    end
    always_ff @(posedge clk_i) begin
        seen_r <= srst_i ? 1'b0 : (seen_r | scan_tick_o);
    end
    sequence msg_step_s;
        $changed(msg_num_o) && msg_valid_o && $past(msg_valid_o);
    endsequence
    sequence selftest_start_s;
        $rose(show_selftest_o);
    endsequence
    bus_one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("bus wait longer than one cycle");
    scan_spacing_a: assert property (scan_tick_o && seen_r |-> gap_r >= SCAN_CYCLES)
        else $error("scan ticks closer than one scan");
    // Tick, then accept and refresh edges: the new number shows two cycles on
    msg_on_tick_a: assert property (msg_step_s |-> $past(scan_tick_o, 2))
        else $error("message changed away from a scan tick");
    msg_range_a: assert property (msg_valid_o && !show_idle_err_o |->
        (msg_num_o % 100) != 0 && (msg_num_o % 100) <= 21 && msg_num_o <= 10'h2cc)
        else $error("message number outside bank range");
    selftest_min_a: assert property (selftest_start_s |-> show_selftest_o[*8])
        else $error("self test ended early");
    selftest_quiet_a: assert property (show_selftest_o |-> !msg_valid_o && !blank_o)
        else $error("message shown during self test");
    inop_quiet_a: assert property (show_inop_o |-> !msg_valid_o && !show_selftest_o)
        else $error("operation while memory inoperative");
    idle_err_a: assert property (show_idle_err_o |-> !show_selftest_o && !show_inop_o)
        else $error("idle error outside run");
    blank_run_a: assert property (blank_o |-> !show_selftest_o && !show_inop_o)
        else $error("blanking outside run");
endmodule

bind priority_message_selector priority_message_selector_checker #(.SCAN_CYCLES(SCAN_CYCLES)) u_chk (
    .clk_i, .srst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .msg_num_o, .msg_valid_o,
    .show_selftest_o, .show_inop_o, .show_idle_err_o, .blank_o, .scan_tick_o);

// [verif/ctl_partner.sv]
module ctl_partner (
    input wire logic clk_i,
    input wire logic [15:0] set_disc_i,
    input wire logic [2:0] set_bank_i,
    input wire logic set_strobe_i,
    output logic [15:0] discrete_o,
    output logic [2:0] bank_sel_o,
    output logic strobe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        discrete_o = 16'h0000;
        bank_sel_o = 3'h0;
        strobe_o = 1'b0;
    end
    // Lines move only just after an edge and then hold until the set values change
    always @(posedge clk_i) begin
        discrete_o <= set_disc_i;
        bank_sel_o <= set_bank_i;
        strobe_o <= set_strobe_i;
    end
endmodule

// [verif/priority_message_selector_tb_top.sv]
module priority_message_selector_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import msg_sel_pkg::*;
    typedef struct packed {logic [15:0] d; logic [2:0] b; logic s; logic [9:0] m;} row_t;
    localparam int SETTLE = 80;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [2:0] avs_address_i = 3'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o, got;
    logic avs_waitrequest_o, msg_valid_o, show_selftest_o, show_inop_o;
    logic show_idle_err_o, blank_o, scan_tick_o, strobe_i, set_strobe = 1'b0;
    logic [15:0] discrete_i, set_disc = 16'h0000;
    logic [2:0] bank_sel_i, set_bank = 3'h0;
    logic [MSG_W-1:0] msg_num_o;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    logic [2:0] ra [5] = '{3'h7, REG_CTRL, REG_DEBOUNCE, REG_SAVER, REG_PROG};
    logic [31:0] rv [5] = '{32'h0, 32'h0000_0002, 32'h0000_0002, 32'h0000_ffff, 32'h0};
    row_t rows [9] = '{'{16'h0000, 3'h0, 1'b1, 10'h011}, '{16'h0006, 3'h0, 1'b1, 10'h002},
        '{16'h0004, 3'h0, 1'b1, 10'h011}, '{16'h0014, 3'h0, 1'b1, 10'h005},
        '{16'h8000, 3'h0, 1'b1, 10'h010}, '{16'h0001, 3'h4, 1'b1, 10'h191},
        '{16'h0001, 3'h7, 1'b1, 10'h2bd}, '{16'h0010, 3'h0, 1'b0, 10'h2bd},
        '{16'h0010, 3'h0, 1'b1, 10'h005}};
`define CHK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, ac); end end
    priority_message_selector #(.SCAN_CYCLES(8), .SELFTEST_CYCLES(20)) u_dut (
        .clk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .discrete_i, .bank_sel_i,
        .strobe_i, .msg_num_o, .msg_valid_o, .show_selftest_o, .show_inop_o,
        .show_idle_err_o, .blank_o, .scan_tick_o);
    ctl_partner u_ctl (.clk_i(clk_i), .set_disc_i(set_disc), .set_bank_i(set_bank),
        .set_strobe_i(set_strobe), .discrete_o(discrete_i), .bank_sel_o(bank_sel_i),
        .strobe_o(strobe_i));
    always #20 clk_i = ~clk_i;
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            end_sim();
        end
    end
    // Request stands until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= ~wr;
        avs_write_i <= wr;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        got = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic drive(input logic [15:0] d, input logic [2:0] b, input logic s, input int w);
        @(posedge clk_i);
        set_disc <= d;
        set_bank <= b;
        set_strobe <= s;
        repeat (w) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        @(negedge clk_i);
        `CHK("msg_valid after reset", 1'b0, msg_valid_o)
        bus(1'b1, 3'h7, 32'hffff_ffff);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, ra[i], 32'h0);
            `CHK("register reset value", rv[i], got)
        end
        bus(1'b1, REG_SAVER, 32'h0000_0020);
        bus(1'b1, REG_PROG, 32'h003f_fff6);
        bus(1'b1, REG_CTRL, 32'h0000_0033);
        n = 0;
        while (show_selftest_o !== 1'b1 && n < 5) begin
            @(negedge clk_i);
            n++;
        end
        n = 0;
        while (show_selftest_o === 1'b1 && n < 1000) begin
            @(negedge clk_i);
            n++;
        end
        `CHK("self test length", 1'b1, n >= 20)
        for (int i = 0; i < 9; i++) begin
            drive(rows[i].d, rows[i].b, rows[i].s, SETTLE);
            `CHK("msg_num row", rows[i].m, msg_num_o)
        end
        drive(16'h0002, 3'h0, 1'b1, 12);
        drive(16'h0010, 3'h0, 1'b1, SETTLE);
        `CHK("msg_num after glitch", 10'h005, msg_num_o)
        drive(16'h0002, 3'h0, 1'b1, 16);
        `CHK("msg_num before debounce", 10'h005, msg_num_o)
        repeat (SETTLE) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("msg_num after debounce", 10'h002, msg_num_o)
        repeat (400) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("saver blank", 1'b1, blank_o)
        drive(16'h0010, 3'h0, 1'b1, SETTLE);
        `CHK("saver wake", 1'b0, blank_o)
        bus(1'b1, REG_PROG, 32'h003d_fff6);
        drive(16'h0000, 3'h0, 1'b1, SETTLE);
        `CHK("idle not programmed", 1'b1, show_idle_err_o)
        bus(1'b1, REG_PROG, 32'h003f_fff6);
        bus(1'b1, REG_CTRL, 32'h0000_0037);
        drive(16'h0000, 3'h0, 1'b0, SETTLE);
        `CHK("twenty idle", 10'h015, msg_num_o)
        drive(16'h0100, 3'h0, 1'b0, SETTLE);
        `CHK("twenty no gate", 10'h009, msg_num_o)
        // Memory state is looked at on entry only, so leave display mode first
        bus(1'b1, REG_CTRL, 32'h0000_0002);
        bus(1'b1, REG_CTRL, 32'h0000_0003);
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("memory inoperative", 1'b1, show_inop_o)
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        bus(1'b0, REG_CTRL, 32'h0);
        `CHK("ctrl after second reset", 32'h0000_0002, got)
        end_sim();
    end
endmodule
